//--- src/ldovbc_regs.sv
// Regulator code and buck control register bank behind the serial engine's byte register port.
// Assumes the port is on sys_clk; sleep_state_n is an asynchronous pin.
`timescale 1ns/1ns

module ldovbc_regs #(
	// Factory variant whose voltage-code registers reset to zero.
	parameter bit LDO_ZERO_VARIANT = 1'b0,
	// Factory variant whose third buck resets into forced pulse-width mode.
	parameter bit BUCK3_PWM_VARIANT = 1'b0
) (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Register port from the serial engine.
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Sleep-state pin, low means sleep.
	input wire logic sleep_state_n,
	// Applied voltage codes of the two linear regulators.
	output logic [3:0] linear_reg_first_code,
	output logic [3:0] linear_reg_second_code,
	// Buck enable requests from sequencing and from the force-on register.
	input wire logic [2:0] buck_seq_en,
	input wire logic [2:0] buck_force_on,
	// Buck operating controls, bit 0 is the first buck.
	output logic [2:0] buck_pwm_force,
	output logic [2:0] buck_run
);

	// Reset values chosen by the factory variant.
	localparam logic [7:0] FIRST_RST = LDO_ZERO_VARIANT ? ldovbc_pkg::LDO_RST_ZERO : ldovbc_pkg::LDO_FIRST_RST_STD;
	localparam logic [7:0] SECOND_RST = LDO_ZERO_VARIANT ? ldovbc_pkg::LDO_RST_ZERO : ldovbc_pkg::LDO_SECOND_RST_STD;
	localparam logic [2:0] MODE_RST = BUCK3_PWM_VARIANT ? ldovbc_pkg::BUCK_MODE_RST_PWM3
		: ldovbc_pkg::BUCK_MODE_RST_STD;

	// Two-stage synchroniser for the sleep pin; only the second stage is read by logic.
	logic sleep_meta_q;
	logic sleep_sync_q;
	// Stored voltage-code registers.
	logic [7:0] first_reg;
	logic [7:0] second_reg;
	// Buck fields.
	logic [2:0] mode_q;
	logic [2:0] mode_d;
	logic [2:0] off_n_q;
	logic [2:0] off_n_d;
	// Address decode.
	logic hit_first;
	logic hit_second;
	logic hit_buck;
	// Read data path.
	logic [7:0] buck_view;
	logic [7:0] rd_mux;
	logic [7:0] rdata_d;
	// Buck output next values.
	logic [2:0] run_d;

	// Decode each mapped offset; an unmapped write is dropped.
	assign hit_first = reg_addr == ldovbc_pkg::LDO_FIRST_OFS;
	assign hit_second = reg_addr == ldovbc_pkg::LDO_SECOND_OFS;
	assign hit_buck = reg_addr == ldovbc_pkg::BUCK_CTRL_OFS;

	// Buck register view; the two top bits are hard zero.
	assign buck_view = {2'h0, mode_q, off_n_q};
	assign mode_d = (reg_wr && hit_buck) ? reg_wdata[ldovbc_pkg::BUCK_MODE_LSB +: ldovbc_pkg::BUCK_N] : mode_q;
	assign off_n_d = (reg_wr && hit_buck) ? reg_wdata[ldovbc_pkg::BUCK_OFF_N_LSB +: ldovbc_pkg::BUCK_N] : off_n_q;

	// Read multiplexer; unmapped offsets answer with a fixed value.
	assign rd_mux = hit_first ? first_reg
		: hit_second ? second_reg
		: hit_buck ? buck_view
		: ldovbc_pkg::UNMAPPED_RDATA;
	assign rdata_d = reg_rd ? rd_mux : reg_rdata;

	// A cleared disable bit wins over both enable sources.
	assign run_d = off_n_q & (buck_seq_en | buck_force_on);

	// Sleep pin synchroniser.
	// The applied codes follow the pin three edges late; a pin pulse shorter than a cycle may be missed.
	// Both stages reset awake, so leaving reset never produces a false entry into sleep.
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			sleep_meta_q <= 1'b1;
			sleep_sync_q <= 1'b1;
		end
		else
		begin
			sleep_meta_q <= sleep_state_n;
			sleep_sync_q <= sleep_meta_q;
		end
	end

	// First regulator's register and code selection.
	ldovbc_code_sel #(
		.RST_VAL(FIRST_RST)
	) u_first (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.wr_en(reg_wr && hit_first),
		.wdata(reg_wdata),
		.sleep_n(sleep_sync_q),
		.reg_q(first_reg),
		.code_q(linear_reg_first_code)
	);

	// Second regulator's register and code selection.
	ldovbc_code_sel #(
		.RST_VAL(SECOND_RST)
	) u_second (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.wr_en(reg_wr && hit_second),
		.wdata(reg_wdata),
		.sleep_n(sleep_sync_q),
		.reg_q(second_reg),
		.code_q(linear_reg_second_code)
	);

	// Buck fields and buck outputs; outputs lag the fields by one cycle.
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			mode_q <= MODE_RST;
			off_n_q <= ldovbc_pkg::BUCK_OFF_N_RST;
			buck_pwm_force <= 3'h0;
			buck_run <= 3'h0;
		end
		else
		begin
			mode_q <= mode_d;
			off_n_q <= off_n_d;
			buck_pwm_force <= mode_q;
			buck_run <= run_d;
		end
	end

	// Read data is captured on a read and then held until the next read.
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			reg_rdata <= 8'h00;
		end
		else
		begin
			reg_rdata <= rdata_d;
		end
	end

	// Sleep code of the first regulator is applied while asleep.
	first_sleep_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!sleep_sync_q |=> linear_reg_first_code == $past(first_reg[7:4]))
		else $error("First regulator not on its sleep code.");

	// Sleep code of the second regulator is applied while asleep.
	second_sleep_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!sleep_sync_q |=> linear_reg_second_code == $past(second_reg[7:4]))
		else $error("Second regulator not on its sleep code.");

	// Normal code of the first regulator is applied while awake.
	first_wake_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		sleep_sync_q |=> linear_reg_first_code == $past(first_reg[3:0]))
		else $error("First regulator not on its normal code.");

	// Normal code of the second regulator is applied while awake.
	second_wake_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		sleep_sync_q |=> linear_reg_second_code == $past(second_reg[3:0]))
		else $error("Second regulator not on its normal code.");

	// Pin low for four edges puts the sleep code out, with no write needed.
	pin_to_code_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(!sleep_state_n && !reg_wr) [*4] |-> linear_reg_first_code == first_reg[7:4])
		else $error("Sleep pin did not reach the applied code in four cycles.");

	// First register reads back what was written, both fields.
	first_readback_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		reg_wr && hit_first ##1 reg_rd && hit_first && !reg_wr |=> reg_rdata == $past(reg_wdata, 2))
		else $error("First register read back wrong.");

	// Reserved buck bits always read zero.
	buck_rsvd_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		reg_rd && hit_buck |=> reg_rdata[7:6] == 2'h0)
		else $error("Reserved buck bits not zero.");

	// A buck register write lands in the mode and disable fields, never in the reserved bits.
	buck_write_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		reg_wr && hit_buck |=> buck_view == {2'h0, $past(reg_wdata[5:0])})
		else $error("Buck register write did not land.");

	// Disable bits come out of reset set.
	buck_reset_a: assert property (@(posedge sys_clk)
		$past(sys_rst) && !sys_rst |-> off_n_q == ldovbc_pkg::BUCK_OFF_N_RST)
		else $error("Disable bits not set after reset.");

	// Mode bits reach the forced-modulation outputs one cycle later.
	pwm_follow_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!$past(sys_rst) |-> buck_pwm_force == $past(mode_q))
		else $error("Forced modulation output does not follow the mode bits.");

	// A cleared disable bit keeps the buck off even with force-on set.
	buck_off_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!off_n_q[0] && buck_force_on[0] |=> !buck_run[0])
		else $error("Buck ran while its disable bit was clear.");

	// No buck runs in the cycle after its disable bit was clear, whatever the enables.
	disable_wins_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!$past(sys_rst) |-> (buck_run & ~$past(off_n_q)) == 3'h0)
		else $error("A disabled buck was running.");

endmodule : ldovbc_regs

//--- src/ldovbc_pkg.sv
// Package of offsets, field positions and reset values for the regulator control registers.
// Assumes byte-wide registers reached through an 8-bit register port of the serial engine.
package ldovbc_pkg;

	// Register offsets on the internal register port.
	localparam logic [7:0] LDO_FIRST_OFS = 8'h9a;
	localparam logic [7:0] LDO_SECOND_OFS = 8'h9b;
	localparam logic [7:0] BUCK_CTRL_OFS = 8'h9c;

	// Field positions inside the voltage-code registers.
	localparam int SLEEP_CODE_LSB = 4;
	localparam int NORMAL_CODE_LSB = 0;
	localparam int CODE_W = 4;

	// Field positions inside the buck control register.
	localparam int BUCK_RSVD_LSB = 6;
	localparam int BUCK_MODE_LSB = 3;
	localparam int BUCK_OFF_N_LSB = 0;
	localparam int BUCK_N = 3;

	// Factory reset values of the voltage-code registers, standard and zeroed variants.
	localparam logic [7:0] LDO_FIRST_RST_STD = 8'haa;
	localparam logic [7:0] LDO_SECOND_RST_STD = 8'hbb;
	localparam logic [7:0] LDO_RST_ZERO = 8'h00;

	// Factory reset values of the buck fields.
	localparam logic [2:0] BUCK_MODE_RST_STD = 3'h0;
	localparam logic [2:0] BUCK_MODE_RST_PWM3 = 3'h4;
	localparam logic [2:0] BUCK_OFF_N_RST = 3'h7;

	// Read value of an unmapped offset.
	localparam logic [7:0] UNMAPPED_RDATA = 8'h00;

endpackage : ldovbc_pkg

//--- src/ldovbc_code_sel.sv
// One linear regulator's code register holding a sleep and a normal voltage code.
// Assumes the sleep-state level arriving here is already synchronised to sys_clk.
`timescale 1ns/1ns

module ldovbc_code_sel #(
	parameter logic [7:0] RST_VAL = 8'h00
) (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Register write side.
	input wire logic wr_en,
	input wire logic [7:0] wdata,
	// Synchronised sleep-state level, low means sleep.
	input wire logic sleep_n,
	// Stored register and the code applied to the regulator.
	output logic [7:0] reg_q,
	output logic [3:0] code_q
);

	// Stored value only changes on a write; the pin never touches it.
	logic [7:0] reg_d;
	// Applied code picked by the sleep level.
	logic [3:0] code_d;

	assign reg_d = wr_en ? wdata : reg_q;
	assign code_d = sleep_n ? reg_q[ldovbc_pkg::NORMAL_CODE_LSB +: ldovbc_pkg::CODE_W]
		: reg_q[ldovbc_pkg::SLEEP_CODE_LSB +: ldovbc_pkg::CODE_W];

	// Register and applied code; the applied code lags the register by one cycle.
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			reg_q <= RST_VAL;
			code_q <= 4'h0;
		end
		else
		begin
			reg_q <= reg_d;
			code_q <= code_d;
		end
	end

	// A written byte is stored whole, both code fields at once.
	field_store_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		wr_en |=> reg_q == $past(wdata))
		else $error("Written byte was not stored.");

	// Without a write the stored value holds, whatever the sleep level does.
	field_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!wr_en && !$past(sys_rst) |=> $stable(reg_q))
		else $error("Stored codes changed without a write.");

	// Normal code is applied while awake.
	normal_pick_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		sleep_n |=> code_q == $past(reg_q[3:0]))
		else $error("Normal code not applied while awake.");

endmodule : ldovbc_code_sel

//--- bench/ldovbc_host.sv
// Host model that reaches the regulator bank through the engine's byte port.
// Assumes each call starts just after a rising edge of sys_clk.
`timescale 1ns/1ns

module ldovbc_host (
	// Clock.
	input wire logic sys_clk,
	// Register port requests.
	output logic [7:0] reg_addr,
	output logic reg_wr,
	output logic [7:0] reg_wdata,
	output logic reg_rd
);
	// Port starts idle.
	initial
	begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_wdata = 8'h00;
		reg_rd = 1'b0;
	end

	// One access held for one edge; calls may follow back to back.
	task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] data);
		reg_addr = addr;
		reg_wr = wr;
		reg_rd = !wr;
		reg_wdata = data;
		@(posedge sys_clk);
		#1;
	endtask : access

	// Release; parked lines carry the inverse so stale values never look held.
	task automatic idle();
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = ~reg_addr;
		reg_wdata = ~reg_wdata;
	endtask : idle
endmodule : ldovbc_host

//--- bench/tb_ldovbc_regs.sv
// Self-checking bench for the regulator code and buck control bank.
// Assumes the standard factory variant and the host model beside it.
`timescale 1ns/1ns

module tb_ldovbc_regs;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic sleep_state_n = 1'b1;
	logic [2:0] buck_seq_en = 3'h0;
	logic [2:0] buck_force_on = 3'h0;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, v, m;
	logic reg_wr, reg_rd;
	logic rd_pend = 1'b0;
	logic [3:0] code_a, code_b;
	logic [2:0] pwm, run;
	logic [7:0] rdata_var; // Read data of the variant bank.
	logic [3:0] code_var; // First applied code of the variant bank.
	logic [2:0] pwm_var; // Forced-modulation outputs of the variant bank.
	logic [31:0] r;
	logic [7:0] exp_q[$]; // Expected read bytes, oldest first.
	int mismatches = 0;
	int n_tests = 0;
	int cycles = 0;

	// Free-running 125 MHz clock.
	always #4 sys_clk = ~sys_clk;

	ldovbc_host host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rd(reg_rd));

	ldovbc_regs dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_state_n(sleep_state_n),
		.linear_reg_first_code(code_a), .linear_reg_second_code(code_b), .buck_seq_en(buck_seq_en),
		.buck_force_on(buck_force_on), .buck_pwm_force(pwm), .buck_run(run));

	// Zeroed, forced-modulation factory variant on the same port; only its reset values are checked.
	ldovbc_regs #(.LDO_ZERO_VARIANT(1'b1), .BUCK3_PWM_VARIANT(1'b1)) dut_variant (.sys_clk(sys_clk),
		.sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
		.reg_rdata(rdata_var), .sleep_state_n(sleep_state_n), .linear_reg_first_code(code_var),
		.linear_reg_second_code(), .buck_seq_en(buck_seq_en), .buck_force_on(buck_force_on),
		.buck_pwm_force(pwm_var), .buck_run());

	// Compares one seen value with its expectation.
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// Queues the expected byte, then issues the read.
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		host.access(1'b0, a, 8'h00);
	endtask : rd

	// Prints the counts and the verdict, then stops.
	task automatic finish_test();
		$display("Counts: %0d compares, %0d mismatches", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : finish_test

	// Read data lands one edge after the read, so the monitor lags reg_rd by one edge.
	always @(posedge sys_clk)
	begin
		if (rd_pend)
			chk(reg_rdata, exp_q.pop_front());
		rd_pend <= reg_rd;
		cycles <= cycles + 1;
		// A hang far beyond the roughly 80 cycles needed is cut short here.
		if (cycles == 2000)
		begin
			mismatches++;
			finish_test();
		end
	end

	// Main sequence.
	initial
	begin
		void'($urandom(32'h6f6a));
		repeat (16) @(posedge sys_clk);
		#1;
		sys_rst = 1'b0;
		@(posedge sys_clk);
		#1;
		// Reset values of both banks; the variant's read data is looked at right after each of the three register reads lands, not after the unmapped read.
		rd(ldovbc_pkg::LDO_FIRST_OFS, ldovbc_pkg::LDO_FIRST_RST_STD);
		chk(rdata_var, ldovbc_pkg::LDO_RST_ZERO);
		rd(ldovbc_pkg::LDO_SECOND_OFS, ldovbc_pkg::LDO_SECOND_RST_STD);
		chk(rdata_var, ldovbc_pkg::LDO_RST_ZERO);
		rd(ldovbc_pkg::BUCK_CTRL_OFS, {2'h0, ldovbc_pkg::BUCK_MODE_RST_STD, ldovbc_pkg::BUCK_OFF_N_RST});
		chk(rdata_var, {2'h0, ldovbc_pkg::BUCK_MODE_RST_PWM3, ldovbc_pkg::BUCK_OFF_N_RST});
		rd(8'h9d, ldovbc_pkg::UNMAPPED_RDATA);
		host.idle();
		chk({4'h0, code_a}, ldovbc_pkg::LDO_FIRST_RST_STD & 8'h0f);
		chk({4'h0, code_b}, ldovbc_pkg::LDO_SECOND_RST_STD & 8'h0f);
		chk({4'h0, code_var}, ldovbc_pkg::LDO_RST_ZERO & 8'h0f);
		chk({5'h00, pwm_var}, {5'h00, ldovbc_pkg::BUCK_MODE_RST_PWM3});
		$display("Reset values test done");
		// Each write is read back on the very next edge.
		v = 8'($urandom);
		m = 8'($urandom);
		host.access(1'b1, ldovbc_pkg::LDO_FIRST_OFS, v);
		rd(ldovbc_pkg::LDO_FIRST_OFS, v);
		host.access(1'b1, ldovbc_pkg::LDO_SECOND_OFS, m);
		rd(ldovbc_pkg::LDO_SECOND_OFS, m);
		host.access(1'b1, ldovbc_pkg::BUCK_CTRL_OFS, 8'hff);
		rd(ldovbc_pkg::BUCK_CTRL_OFS, 8'h3f);
		host.idle();
		repeat (2) @(posedge sys_clk);
		#1;
		chk({4'h0, code_a}, {4'h0, v[3:0]});
		chk({4'h0, code_b}, {4'h0, m[3:0]});
		$display("Write and read back test done");
		// The pin needs three edges to reach the codes; the fourth leaves margin.
		sleep_state_n = 1'b0;
		repeat (4) @(posedge sys_clk);
		#1;
		chk({4'h0, code_a}, {4'h0, v[7:4]});
		chk({4'h0, code_b}, {4'h0, m[7:4]});
		rd(ldovbc_pkg::LDO_FIRST_OFS, v);
		rd(ldovbc_pkg::LDO_SECOND_OFS, m);
		host.idle();
		sleep_state_n = 1'b1;
		repeat (4) @(posedge sys_clk);
		#1;
		chk({4'h0, code_a}, {4'h0, v[3:0]});
		chk({4'h0, code_b}, {4'h0, m[3:0]});
		// Software keeps both codes equal, so sleep must not move the second regulator.
		host.access(1'b1, ldovbc_pkg::LDO_SECOND_OFS, {m[3:0], m[3:0]});
		host.idle();
		sleep_state_n = 1'b0;
		repeat (4) @(posedge sys_clk);
		#1;
		chk({4'h0, code_b}, {4'h0, m[3:0]});
		sleep_state_n = 1'b1;
		$display("Sleep switch test done");
		for (int i = 0; i < 8; i++)
		begin
			r = $urandom;
			buck_seq_en = r[10:8];
			buck_force_on = r[13:11];
			host.access(1'b1, ldovbc_pkg::BUCK_CTRL_OFS, r[7:0]);
			host.idle();
			repeat (2) @(posedge sys_clk);
			#1;
			chk({5'h00, pwm}, {5'h00, r[5:3]});
			chk({5'h00, run}, {5'h00, r[2:0] & (r[10:8] | r[13:11])});
		end
		// All enables up and all disable bits clear: every buck must stay off.
		buck_seq_en = 3'h7;
		buck_force_on = 3'h7;
		host.access(1'b1, ldovbc_pkg::BUCK_CTRL_OFS, 8'h00);
		host.idle();
		repeat (2) @(posedge sys_clk);
		#1;
		chk({5'h00, run}, 8'h00);
		chk({5'h00, pwm}, 8'h00);
		$display("Buck control test done");
		// A second reset in mid-run must bring the reset values back.
		sys_rst = 1'b1;
		repeat (4) @(posedge sys_clk);
		#1;
		sys_rst = 1'b0;
		rd(ldovbc_pkg::LDO_FIRST_OFS, ldovbc_pkg::LDO_FIRST_RST_STD);
		rd(ldovbc_pkg::BUCK_CTRL_OFS, {2'h0, ldovbc_pkg::BUCK_MODE_RST_STD, ldovbc_pkg::BUCK_OFF_N_RST});
		host.idle();
		@(posedge sys_clk);
		#1;
		$display("Mid-run reset test done");
		finish_test();
	end
endmodule : tb_ldovbc_regs
